/* File: lvpecl_divider_pkg.sv */
// Shared register map, field layout and reset values of the channel dividers
package lvpecl_divider_pkg;

    // Register offsets
    localparam logic [8:0] DIV0_CYCLE_COUNTS_OFS      = 9'h190;
    localparam logic [8:0] DIV0_CONTROL_OFS           = 9'h191;
    localparam logic [8:0] DIV0_ROUTING_CORRECTION_OFS = 9'h192;
    localparam logic [8:0] DIV1_CYCLE_COUNTS_OFS      = 9'h193;
    localparam logic [8:0] DIV1_CONTROL_OFS           = 9'h194;
    localparam logic [8:0] DIVIDER_STATUS_OFS         = 9'h19F;

    // Field positions
    localparam int LOW_COUNT_LSB   = 4;
    localparam int HIGH_COUNT_LSB  = 0;
    localparam int BYPASS_BIT      = 7;
    localparam int SYNC_IGNORE_BIT = 6;
    localparam int FORCE_LEVEL_BIT = 5;
    localparam int START_HIGH_BIT  = 4;
    localparam int PHASE_LSB       = 0;
    localparam int DIRECT_ROUTE_BIT = 1;
    localparam int DUTY_CORRECTION_DISABLE_BIT = 0;

    // Reset values and the routing register write mask
    localparam logic [7:0] DIV0_CYCLE_COUNTS_RESET       = 8'h00;
    localparam logic [7:0] DIV0_CONTROL_RESET            = 8'h80;
    localparam logic [7:0] DIV0_ROUTING_CORRECTION_RESET = 8'h00;
    localparam logic [7:0] DIV1_CYCLE_COUNTS_RESET       = 8'hBB;
    localparam logic [7:0] DIV1_CONTROL_RESET            = 8'h00;
    localparam logic [1:0] ROUTING_CORRECTION_MASK       = 2'h3;

    // Clock source select codes
    localparam logic [1:0] SOURCE_EXTERNAL   = 2'h0;
    localparam logic [1:0] SOURCE_NO_EFFECT  = 2'h1;
    localparam logic [1:0] SOURCE_OSCILLATOR = 2'h2;

    typedef enum logic [0:0] {
        ST_DELAY = 1'b0,
        ST_RUN   = 1'b1
    } divider_state_e;

    // Count loaded when the output enters a level: the field of that level
    function automatic logic [3:0] segment_count(input logic level,
                                                 input logic [3:0] low_count,
                                                 input logic [3:0] high_count);
        segment_count = level ? high_count : low_count;
    endfunction : segment_count

endpackage : lvpecl_divider_pkg

/* File: channel_divider.sv */
// One programmable low/high divider channel with bypass, forcing and sync restart
`timescale 1ns/10ps
`default_nettype none
module channel_divider
    import lvpecl_divider_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Divider input clock level and rising-edge pulse, and the sync restart pulse
    input  wire logic       in_level,
    input  wire logic       in_tick,
    input  wire logic       sync_event,
    // Configuration
    input  wire logic [3:0] low_count,
    input  wire logic [3:0] high_count,
    input  wire logic       bypass,
    input  wire logic       sync_ignore,
    input  wire logic       force_level,
    input  wire logic       start_high,
    input  wire logic [3:0] phase_offset,
    // Result
    output logic            div_out,
    output logic            delaying
);

    divider_state_e state_reg;
    logic [3:0]     count_reg;
    logic [3:0]     delay_reg;
    logic           level_reg;

    // Counting logic is frozen while bypassed, standing in for its power-down
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= ST_DELAY;
            delay_reg <= 4'h0;
            count_reg <= 4'h0;
            level_reg <= 1'b0;
        end else if (!bypass) begin // R4
            if (sync_event && !sync_ignore) begin // R6
                state_reg <= ST_DELAY; // R16
                delay_reg <= phase_offset; // R10
            end else if (in_tick) begin
                unique case (state_reg)
                    ST_DELAY: begin
                        if (delay_reg == 4'h0) begin
                            state_reg <= ST_RUN;
                            level_reg <= start_high; // R9
                            count_reg <= segment_count(start_high, low_count, high_count);
                        end else begin
                            delay_reg <= delay_reg - 4'h1;
                        end
                    end
                    ST_RUN: begin
                        if (count_reg == 4'h0) begin
                            level_reg <= ~level_reg; // R1 R2
                            count_reg <= segment_count(~level_reg, low_count, high_count);
                        end else begin
                            count_reg <= count_reg - 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Bypass wins over forcing; a set sync-ignore bit forces the output to the force-level bit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_out <= 1'b0;
        end else if (bypass) begin
            div_out <= in_level; // R4 R8
        end else if (sync_ignore) begin
            div_out <= force_level; // R7
        end else begin
            div_out <= level_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            delaying <= 1'b1;
        end else begin
            delaying <= (state_reg == ST_DELAY);
        end
    end

endmodule : channel_divider
`default_nettype wire

/* File: lvpecl_channel_dividers.sv */
// Top of the first two LVPECL channel dividers: registers, sync, routing, outputs
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] The output stays low for the low-count field plus one input clock cycles.
// [R2] The output stays high for the high-count field plus one input clock cycles.
// [R3] Reset loads counts of zero into divider 0 and eleven into divider 1.
// [R4] Bypass freezes the counting logic and passes the input clock to the output.
// [R5] Divider 0 resets into bypass and divider 1 resets dividing.
// [R6] A cleared sync-ignore bit obeys the chip sync signal; a set one ignores it.
// [R7] Force-level drives the output statically, but only with sync-ignore set.
// [R8] Force-level has no effect while the divider is bypassed.
// [R9] The start-level bit picks the level the output starts with.
// [R10] A 4-bit phase offset in input clock cycles delays the output; it resets to zero.
// [R11] With direct-route cleared the first pair is driven by divider 0.
// [R12] Direct-route with source select 10b sends the oscillator to the first pair.
// [R13] Direct-route with source select 00b sends the input clock to the first pair; here external_clk is routed there, not divider_in_clk.
// [R14] Direct-route with source select 01b leaves the routing unchanged.
// [R15] Divider 0 applies duty-cycle correction unless its disable bit is one.
// [R16] An obeyed sync restarts the divider at its start level after the phase delay.
module lvpecl_channel_dividers
    import lvpecl_divider_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,

    // Register port
    input  wire logic [8:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,

    // Clock sources, sampled as synchronous levels
    input  wire logic       divider_in_clk,
    input  wire logic       oscillator_clk,
    input  wire logic       external_clk,

    // Chip-level controls
    input  wire logic       chip_sync,
    input  wire logic [1:0] clock_source_select,

    // First output pair
    output logic            first_pair_output_a,
    output logic            first_pair_output_b,

    // Second output pair
    output logic            second_pair_output_a,
    output logic            second_pair_output_b,

    // Duty-cycle correction enable toward the first pair driver
    output logic            duty_correction_enable
);

    // Register storage
    logic [7:0] div0_counts_reg;
    logic [7:0] div0_control_reg;
    logic [1:0] div0_routing_reg;
    logic [7:0] div1_counts_reg;
    logic [7:0] div1_control_reg;

    // Input edge detection
    logic       in_clk_prev_reg;
    logic       in_tick;
    logic       sync_prev_reg;
    logic       sync_event;

    // Divider results
    logic       div0_out;
    logic       div1_out;
    logic       div0_delaying;
    logic       div1_delaying;

    // Routing
    logic       direct_route;
    logic       first_pair_next;
    logic [7:0] status_value;
    logic [7:0] rdata_next;

    // Register writes, one process per register

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div0_counts_reg <= DIV0_CYCLE_COUNTS_RESET; // R3
        end else if (reg_wr && reg_addr == DIV0_CYCLE_COUNTS_OFS) begin
            div0_counts_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div0_control_reg <= DIV0_CONTROL_RESET; // R5 R10
        end else if (reg_wr && reg_addr == DIV0_CONTROL_OFS) begin
            div0_control_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div0_routing_reg <= DIV0_ROUTING_CORRECTION_RESET[1:0];
        end else if (reg_wr && reg_addr == DIV0_ROUTING_CORRECTION_OFS) begin
            div0_routing_reg <= reg_wdata[1:0] & ROUTING_CORRECTION_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div1_counts_reg <= DIV1_CYCLE_COUNTS_RESET; // R3
        end else if (reg_wr && reg_addr == DIV1_CYCLE_COUNTS_OFS) begin
            div1_counts_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div1_control_reg <= DIV1_CONTROL_RESET; // R5 R10
        end else if (reg_wr && reg_addr == DIV1_CONTROL_OFS) begin
            div1_control_reg <= reg_wdata;
        end
    end

    // Read-only status: live divider state and the chosen first-pair source
    always_comb begin
        status_value = 8'h00;
        status_value[0] = div0_out;
        status_value[1] = div1_out;
        status_value[2] = div0_delaying;
        status_value[3] = div1_delaying;
        status_value[4] = direct_route;
        status_value[5] = duty_correction_enable;
    end

    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        unique case (reg_addr)
            DIV0_CYCLE_COUNTS_OFS: begin
                rdata_next = div0_counts_reg;
            end
            DIV0_CONTROL_OFS: begin
                rdata_next = div0_control_reg;
            end
            DIV0_ROUTING_CORRECTION_OFS: begin
                rdata_next = {6'h00, div0_routing_reg};
            end
            DIV1_CYCLE_COUNTS_OFS: begin
                rdata_next = div1_counts_reg;
            end
            DIV1_CONTROL_OFS: begin
                rdata_next = div1_control_reg;
            end
            DIVIDER_STATUS_OFS: begin
                rdata_next = status_value;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Edge detection of the divider input clock; each rising edge is one count
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_clk_prev_reg <= 1'b0;
        end else begin
            in_clk_prev_reg <= divider_in_clk;
        end
    end

    assign in_tick = divider_in_clk & ~in_clk_prev_reg;

    // Only the rising edge of sync restarts, so a held level restarts once
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_prev_reg <= 1'b0;
        end else begin
            sync_prev_reg <= chip_sync;
        end
    end

    assign sync_event = chip_sync & ~sync_prev_reg;

    // Divider 0
    channel_divider u_divider0 (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .in_level     (divider_in_clk),
        .in_tick      (in_tick),
        .sync_event   (sync_event),
        .low_count    (div0_counts_reg[LOW_COUNT_LSB +: 4]),
        .high_count   (div0_counts_reg[HIGH_COUNT_LSB +: 4]),
        .bypass       (div0_control_reg[BYPASS_BIT]),
        .sync_ignore  (div0_control_reg[SYNC_IGNORE_BIT]),
        .force_level  (div0_control_reg[FORCE_LEVEL_BIT]),
        .start_high   (div0_control_reg[START_HIGH_BIT]),
        .phase_offset (div0_control_reg[PHASE_LSB +: 4]),
        .div_out      (div0_out),
        .delaying     (div0_delaying)
    );

    // Divider 1
    channel_divider u_divider1 (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .in_level     (divider_in_clk),
        .in_tick      (in_tick),
        .sync_event   (sync_event),
        .low_count    (div1_counts_reg[LOW_COUNT_LSB +: 4]),
        .high_count   (div1_counts_reg[HIGH_COUNT_LSB +: 4]),
        .bypass       (div1_control_reg[BYPASS_BIT]),
        .sync_ignore  (div1_control_reg[SYNC_IGNORE_BIT]),
        .force_level  (div1_control_reg[FORCE_LEVEL_BIT]),
        .start_high   (div1_control_reg[START_HIGH_BIT]),
        .phase_offset (div1_control_reg[PHASE_LSB +: 4]),
        .div_out      (div1_out),
        .delaying     (div1_delaying)
    );

    // Direct routing only counts for the two source codes that name a clock
    assign direct_route = div0_routing_reg[DIRECT_ROUTE_BIT]
                        && (clock_source_select == SOURCE_OSCILLATOR
                         || clock_source_select == SOURCE_EXTERNAL);

    // Code 11b is treated like 01b: no effect, divider 0 keeps the pair
    always_comb begin
        if (!div0_routing_reg[DIRECT_ROUTE_BIT]) begin
            first_pair_next = div0_out; // R11
        end else begin
            unique case (clock_source_select)
                SOURCE_OSCILLATOR: begin
                    first_pair_next = oscillator_clk; // R12
                end
                SOURCE_EXTERNAL: begin
                    first_pair_next = external_clk; // R13
                end
                SOURCE_NO_EFFECT: begin
                    first_pair_next = div0_out; // R14
                end
                default: begin
                    first_pair_next = div0_out;
                end
            endcase
        end
    end

    // First pair: complementary legs from one flip-flop each
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            first_pair_output_a <= 1'b0;
            first_pair_output_b <= 1'b1;
        end else begin
            first_pair_output_a <= first_pair_next;
            first_pair_output_b <= ~first_pair_next;
        end
    end

    // Second pair follows divider 1 with no routing choice here
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            second_pair_output_a <= 1'b0;
            second_pair_output_b <= 1'b1;
        end else begin
            second_pair_output_a <= div1_out;
            second_pair_output_b <= ~div1_out;
        end
    end

    // Correction itself is done by the analog driver; this is its enable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            duty_correction_enable <= 1'b1;
        end else begin
            duty_correction_enable <= ~div0_routing_reg[DUTY_CORRECTION_DISABLE_BIT]; // R15
        end
    end

endmodule : lvpecl_channel_dividers
`default_nettype wire

/* File: divider_monitor.sv */
// Concurrent checks on the channel divider top ports
`timescale 1ns/10ps
`default_nettype none
module divider_monitor
    import lvpecl_divider_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Register port
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Sources and controls
    input wire logic       divider_in_clk,
    input wire logic       oscillator_clk,
    input wire logic       external_clk,
    input wire logic       chip_sync,
    input wire logic [1:0] clock_source_select,
    // Outputs
    input wire logic       first_pair_output_a,
    input wire logic       first_pair_output_b,
    input wire logic       second_pair_output_a,
    input wire logic       second_pair_output_b,
    input wire logic       duty_correction_enable
);
    logic [7:0] cnt0_reg, ctl0_reg, rte0_reg, cnt1_reg, ctl1_reg, shadow_rd;
    logic [1:0] live_reg;

    // Shadow copy of the register file, mirrored from the write strobes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt0_reg <= 8'h00;
            ctl0_reg <= 8'h80;
            rte0_reg <= 8'h00;
            cnt1_reg <= 8'hBB;
            ctl1_reg <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                DIV0_CYCLE_COUNTS_OFS:       cnt0_reg <= reg_wdata;
                DIV0_CONTROL_OFS:            ctl0_reg <= reg_wdata;
                DIV0_ROUTING_CORRECTION_OFS: rte0_reg <= {6'h00, reg_wdata[1:0]};
                DIV1_CYCLE_COUNTS_OFS:       cnt1_reg <= reg_wdata;
                DIV1_CONTROL_OFS:            ctl1_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Cycles since reset release, so delayed samples never reach into reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            live_reg <= 2'h0;
        end else if (live_reg != 2'h3) begin
            live_reg <= live_reg + 2'h1;
        end
    end

    always_comb begin
        case (reg_addr)
            DIV0_CYCLE_COUNTS_OFS:       shadow_rd = cnt0_reg;
            DIV0_CONTROL_OFS:            shadow_rd = ctl0_reg;
            DIV0_ROUTING_CORRECTION_OFS: shadow_rd = rte0_reg;
            DIV1_CYCLE_COUNTS_OFS:       shadow_rd = cnt1_reg;
            DIV1_CONTROL_OFS:            shadow_rd = ctl1_reg;
            default:                     shadow_rd = 8'h00;
        endcase
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_first_legs_paired: assert property (first_pair_output_b == !first_pair_output_a)
        else $error("first pair legs not complementary");
    a_read_value_match: assert property ($past(reg_rd) && $past(reg_addr) >= DIV0_CYCLE_COUNTS_OFS
        && $past(reg_addr) <= DIV1_CONTROL_OFS |-> reg_rdata == $past(shadow_rd))
        else $error("read data differs from register contents");
    a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_div1_bypass_follow: assert property (live_reg == 2'h3 && ctl1_reg[7] && $past(ctl1_reg[7], 3)
        |-> second_pair_output_a == $past(divider_in_clk, 2))
        else $error("bypassed divider 1 does not pass its input");
    a_div0_bypass_follow: assert property (live_reg == 2'h3 && ctl0_reg[7] && $past(ctl0_reg[7], 3)
        && !rte0_reg[1] && !$past(rte0_reg[1], 3) |-> first_pair_output_a == $past(divider_in_clk, 2))
        else $error("bypassed divider 0 does not reach first pair");
    a_force_high_static: assert property (ctl1_reg[7:5] == 3'b011 && $past(ctl1_reg[7:5], 4) == 3'b011
        |-> second_pair_output_a)
        else $error("forced divider output not high");
    a_force_low_static: assert property (ctl1_reg[7:5] == 3'b010 && $past(ctl1_reg[7:5], 4) == 3'b010
        |-> !second_pair_output_a)
        else $error("forced divider output not low");
    a_duty_enable_level: assert property (rte0_reg[0] == $past(rte0_reg[0])
        |-> duty_correction_enable == !rte0_reg[0])
        else $error("duty correction enable wrong");
    a_direct_osc_route: assert property ((rte0_reg[1] && clock_source_select == SOURCE_OSCILLATOR
        && $stable(oscillator_clk))[*4] |-> first_pair_output_a == oscillator_clk)
        else $error("oscillator not routed to first pair");
    a_direct_ext_route: assert property ((rte0_reg[1] && clock_source_select == SOURCE_EXTERNAL
        && $stable(external_clk))[*4] |-> first_pair_output_a == external_clk)
        else $error("external clock not routed to first pair");
    a_select_no_effect: assert property ((live_reg == 2'h3 && rte0_reg[1] && ctl0_reg[7]
        && clock_source_select == SOURCE_NO_EFFECT)[*4] |-> first_pair_output_a == $past(divider_in_clk, 2))
        else $error("inert source select changed routing");
endmodule : divider_monitor

bind lvpecl_channel_dividers divider_monitor i_mon (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .divider_in_clk(divider_in_clk), .oscillator_clk(oscillator_clk), .external_clk(external_clk),
    .chip_sync(chip_sync), .clock_source_select(clock_source_select),
    .first_pair_output_a(first_pair_output_a), .first_pair_output_b(first_pair_output_b),
    .second_pair_output_a(second_pair_output_a), .second_pair_output_b(second_pair_output_b),
    .duty_correction_enable(duty_correction_enable));
`default_nettype wire

/* File: pair_load.sv */
// Downstream load on one differential pair, measuring level run lengths
`timescale 1ns/10ps
`default_nettype none
module pair_load (
    // Clock
    input wire logic  clock,
    // Pair legs
    input wire logic  pos,
    input wire logic  neg,
    // Last run lengths in system clocks
    output logic [7:0] high_len,
    output logic [7:0] low_len
);
    logic       prev_reg = 1'b0;
    logic [7:0] run_reg  = 8'h00;
    logic       level;

    // A receiver only sees a new level when the legs disagree
    assign level = (pos != neg) ? pos : prev_reg;

    always @(posedge clock) begin
        prev_reg <= level;
        if (level != prev_reg) begin
            if (prev_reg) begin
                high_len <= run_reg;
            end else begin
                low_len <= run_reg;
            end
            run_reg <= 8'h01;
        end else if (run_reg != 8'hFF) begin
            run_reg <= run_reg + 8'h01;
        end
    end
endmodule : pair_load
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the channel dividers
`timescale 1ns/10ps
`default_nettype none
module testbench
    import lvpecl_divider_pkg::*;
;
    logic       clock, sys_rst, reg_wr, reg_rd, divider_in_clk, oscillator_clk, external_clk, chip_sync;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, hi0, lo0, hi1, lo1;
    logic [1:0] clock_source_select;
    logic       pa0, pb0, pa1, pb1, duty_en, in_run;
    int         fails = 0;
    int         compares = 0;
    logic [7:0] rst_t [5] = '{8'h00, 8'h80, 8'h00, 8'hBB, 8'h00};
    logic [1:0] sel_t [4] = '{2'h2, 2'h0, 2'h1, 2'h2};
    logic [3:0] cfg_t [4] = '{4'hD, 4'hB, 4'hE, 4'h6};

    lvpecl_channel_dividers i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .divider_in_clk(divider_in_clk),
        .oscillator_clk(oscillator_clk), .external_clk(external_clk), .chip_sync(chip_sync),
        .clock_source_select(clock_source_select), .first_pair_output_a(pa0), .first_pair_output_b(pb0),
        .second_pair_output_a(pa1), .second_pair_output_b(pb1), .duty_correction_enable(duty_en));
    pair_load i_load0 (.clock(clock), .pos(pa0), .neg(pb0), .high_len(hi0), .low_len(lo0));
    pair_load i_load1 (.clock(clock), .pos(pa1), .neg(pb1), .high_len(hi1), .low_len(lo1));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Free-running divider input: one count every two system clocks
    always @(posedge clock) begin
        if (in_run) begin
            divider_in_clk <= ~divider_in_clk;
        end
    end

    task automatic complete_run();
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc

    // Single input count by hand, then time for it to reach the pair
    task automatic tick();
        @(posedge clock);
        divider_in_clk <= 1'b1;
        @(posedge clock);
        divider_in_clk <= 1'b0;
        wait_cyc(4);
    endtask : tick

    task automatic sync_tick();
        @(posedge clock);
        chip_sync <= 1'b1;
        @(posedge clock);
        chip_sync <= 1'b0;
        tick();
    endtask : sync_tick

    initial begin
        #(3000 * 50);
        fails++;
        complete_run();
    end

    initial begin
        {sys_rst, reg_wr, reg_rd, divider_in_clk, oscillator_clk, external_clk, chip_sync, in_run} = 8'h80;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        clock_source_select = 2'h1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(9'h190 + 9'(i), rst_t[i]);
        end
        rd(9'h1A0, 8'h00);
        rd(9'h19F, 8'h2C);
        wr(9'h192, 8'hFF);
        rd(9'h192, 8'h03);
        wr(9'h192, 8'h01);
        wait_cyc(3);
        chk({7'h00, duty_en}, 8'h00);
        wr(9'h192, 8'h00);
        in_run <= 1'b1;
        wait_cyc(120);
        chk(hi1, 8'h18);
        chk(lo1, 8'h18);
        wr(9'h193, 8'h31);
        wait_cyc(80);
        chk(lo1, 8'h08);
        chk(hi1, 8'h04);
        wr(9'h190, 8'h12);
        wr(9'h191, 8'h00);
        wait_cyc(60);
        chk(lo0, 8'h04);
        chk(hi0, 8'h06);
        wr(9'h194, 8'h60);
        wait_cyc(20);
        chk({7'h00, pa1}, 8'h01);
        wr(9'h194, 8'hE0);
        wait_cyc(12);
        chk(hi1, 8'h01);
        chk(lo1, 8'h01);
        wr(9'h191, 8'h80);
        @(posedge clock);
        in_run <= 1'b0;
        // Stop the toggler first so the input is never set by two processes at one edge
        @(posedge clock);
        divider_in_clk <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            clock_source_select <= sel_t[i];
            oscillator_clk <= cfg_t[i][2];
            external_clk <= cfg_t[i][1];
            wr(9'h192, {6'h00, cfg_t[i][3], 1'b0});
            wait_cyc(6);
            chk({7'h00, pa0}, {7'h00, cfg_t[i][0]});
        end
        // Long levels so only the restart can move the output
        wr(9'h193, 8'hFF);
        wr(9'h194, 8'h00);
        sync_tick();
        chk({7'h00, pa1}, 8'h00);
        wr(9'h194, 8'h13);
        sync_tick();
        tick();
        tick();
        chk({7'h00, pa1}, 8'h00);
        tick();
        chk({7'h00, pa1}, 8'h01);
        wr(9'h194, 8'h40);
        sync_tick();
        chk({7'h00, pa1}, 8'h00);
        wr(9'h194, 8'h00);
        wait_cyc(3);
        chk({7'h00, pa1}, 8'h01);
        sync_tick();
        chk({7'h00, pa1}, 8'h00);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
